// *** logic/rbf_defs.vh ***
// Constants for the return burst formatter
`ifndef RBF_DEFS_VH
`define RBF_DEFS_VH
`define RBF_OFS_CTRL     8'h00
`define RBF_OFS_SLOT     8'h04
`define RBF_OFS_BCFG     8'h08
`define RBF_OFS_SAC      8'h0C
`define RBF_OFS_PID      8'h10
`define RBF_OFS_STAT     8'h14
`define RBF_OFS_DELAY    8'h18
`define RBF_OFS_PRE      8'h40
`define RBF_CTRL_EN      0
`define RBF_CTRL_DYN     1
`define RBF_CTRL_CRC     2
`define RBF_CTRL_AFC     3
`define RBF_CTRL_AFCPL   4
`define RBF_CTRL_CELL    5
`define RBF_CTRL_ACM     6
`define RBF_CTRL_TAP     7
`define RBF_CTRL_RST     32'h0000_0000
`define RBF_BCFG_RST     32'h0000_0000
`define RBF_KIND_TRF     2'h0
`define RBF_KIND_CAP     2'h1
`define RBF_KIND_SYNC    2'h2
`define RBF_KIND_LOGON   2'h3
`define RBF_RAND_SEED    15'h4A80
`define RBF_CRC_INIT     16'hFFFF
`define RBF_CRC_POLY     16'h1021
`define RBF_TS_LEN       16'h00BC
`define RBF_CELL_LEN     16'h0035
`define RBF_TS_AFC_POS   8'h03
`define RBF_RESP_OKAY    2'h0
`define RBF_RESP_SLVERR  2'h2
`endif

// *** logic/rbf_pre_mem.v ***
// Preamble pattern store with registered read
`timescale 1ns/1ps
`default_nettype none
module rbf_pre_mem #(
  parameter DW = 32,
  parameter AW = 4
) (
  input  wire          clk,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data_reg
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_reg <= mem[rd_addr];
  end
endmodule // rbf_pre_mem
`default_nettype wire

// *** logic/rbf_formatter.v ***
// Return burst formatter: randomizer, CRC, coder, preamble, QPSK mapper
//
// Behaviour
// RL1 - Every burst is randomized before any channel coding.
// RL2 - CRC-16 appended to sync and logon bursts when enabled.
// RL3 - CRC runs over randomized bits, before the coder.
// RL4 - Coder applied to traffic, sync, logon; taps set by config.
// RL5 - Gray-coded absolute QPSK, no differential encoding.
// RL6 - After preamble, first coder output to I, second to Q.
// RL7 - Sync access-control field length and layout from slot config.
// RL8 - Adaptation field control set to 10 without payload, 11 with.
// RL9 - Sync access-control field carries group and session numbers.
// RL10 - Management id differs from user data id.
// RL11 - Link quality and requested modcod subfield sent when enabled.
// RL12 - Slot numbers increase within a frame; violations flagged.
// RL13 - Bursts start only when all four slot key fields match.
// RL14 - Superframe id covers continuous superframes.
// RL15 - Fixed mode: parameter changes apply in later superframe after delay.
// RL16 - Dynamic mode: parameters may change between successive bursts.
// RL17 - Constant-rate grant lasts whole session.
// RL18 - Rate-based dynamic request carried in access-control field.
// RL19 - Stale rate allocations cleared after timeout.
// RL20 - No rate capacity at superframe maximum.
// RL21 - Four burst kinds selected by terminal action.
// RL22 - MPEG traffic payload is whole 188-byte packets.
// RL23 - Cell traffic payload is 53-byte cells after optional prefix.
// RL24 - Randomizer reloaded at start of every burst.
`timescale 1ns/1ps
`default_nettype none
`include "rbf_defs.vh"
module rbf_formatter #(
  parameter PRE_AW = 4
) (
  input  wire        CLK,
  input  wire        ARST_N,
  input  wire [7:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [7:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  input  wire        BURST_START,
  input  wire [1:0]  BURST_KIND,
  input  wire [7:0]  SLOT_SFID,
  input  wire [7:0]  SLOT_SFCNT,
  input  wire [7:0]  SLOT_FRAME,
  input  wire [7:0]  SLOT_NUM,
  output wire        BURST_READY,
  input  wire [7:0]  DIN,
  input  wire        DIN_VALID,
  output wire        DIN_READY,
  output reg         SYM_VALID,
  output reg         SYM_I,
  output reg         SYM_Q,
  output reg         BURST_DONE
);
  localparam ST_IDLE = 3'h0;
  localparam ST_PRE  = 3'h1;
  localparam ST_BYTE = 3'h2;
  localparam ST_BIT  = 3'h3;
  localparam ST_CRC  = 3'h4;

  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  stb;
    integer k;
    begin
      wmerge = old;
      for (k = 0; k < 4; k = k + 1)
        if (stb[k])
          wmerge[k*8 +: 8] = dat[k*8 +: 8];
    end
  endfunction

  // CRC-16 step on one bit
  function [15:0] crc_step;
    input [15:0] c;
    input        b;
    begin
      crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `RBF_CRC_POLY : 16'h0000);
    end
  endfunction

  reg  [31:0] ctrl_reg, slot_reg, bcfg_reg, sac_reg, pid_reg, delay_reg;
  reg  [31:0] cfg_act_reg, cfg_pend_reg, cfg_use_reg;
  reg  [7:0]  pend_cnt_reg;
  reg         pend_reg;
  reg         slot_err_reg, miss_reg;
  reg  [15:0] burst_cnt_reg, crc_last_reg;
  reg  [7:0]  aw_addr_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg         aw_have_reg, w_have_reg;
  reg  [2:0]  state_reg;
  reg  [1:0]  kind_reg;
  reg  [7:0]  pre_cnt_reg;
  reg         pre_ph_reg;
  reg  [15:0] byte_cnt_reg, total_reg;
  reg  [7:0]  pkt_pos_reg;
  reg  [2:0]  hdr_cnt_reg;
  reg  [7:0]  sh_reg;
  reg  [3:0]  bit_cnt_reg;
  reg  [14:0] lfsr_reg;
  reg  [15:0] crc_reg;
  reg  [2:0]  enc_reg;
  reg         crc_on_reg;
  reg  [7:0]  last_sfid_reg, last_sfcnt_reg, last_frame_reg, last_slot_reg;
  reg         seen_reg;
  wire [31:0] pre_word;

  wire wr_go   = aw_have_reg && w_have_reg && !S_AXI_BVALID;
  wire [31:0] wr_val = w_data_reg;
  wire wr_ctrl = wr_go && aw_addr_reg == `RBF_OFS_CTRL;
  wire wr_slot = wr_go && aw_addr_reg == `RBF_OFS_SLOT;
  wire wr_bcfg = wr_go && aw_addr_reg == `RBF_OFS_BCFG;
  wire wr_sac  = wr_go && aw_addr_reg == `RBF_OFS_SAC;
  wire wr_pid  = wr_go && aw_addr_reg == `RBF_OFS_PID;
  wire wr_stat = wr_go && aw_addr_reg == `RBF_OFS_STAT;
  wire wr_dly  = wr_go && aw_addr_reg == `RBF_OFS_DELAY;
  wire wr_pre  = wr_go && aw_addr_reg[7:6] == `RBF_OFS_PRE >> 6;
  wire wr_map  = wr_ctrl | wr_slot | wr_bcfg | wr_sac | wr_pid | wr_stat | wr_dly | wr_pre;

  assign S_AXI_AWREADY = !aw_have_reg;
  assign S_AXI_WREADY  = !w_have_reg;
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  wire pid_clash = pid_reg[12:0] == pid_reg[28:16];                        // RL10
  wire dyn       = ctrl_reg[`RBF_CTRL_DYN];
  wire idle      = state_reg == ST_IDLE;
  assign BURST_READY = idle && ctrl_reg[`RBF_CTRL_EN];

  // Slot key: all four fields must match the assigned slot
  wire key_ok = SLOT_SFID == slot_reg[7:0] && SLOT_SFCNT == slot_reg[15:8]
             && SLOT_FRAME == slot_reg[23:16] && SLOT_NUM == slot_reg[31:24]; // RL13
  wire start_try = BURST_START && BURST_READY;
  wire start_ok  = start_try && key_ok;
  wire same_frame = seen_reg && SLOT_SFID == last_sfid_reg
             && SLOT_SFCNT == last_sfcnt_reg && SLOT_FRAME == last_frame_reg;
  wire order_bad = start_ok && same_frame && SLOT_NUM <= last_slot_reg;    // RL12
  wire new_sf    = !seen_reg || SLOT_SFCNT != last_sfcnt_reg || SLOT_SFID != last_sfid_reg;
  wire apply_pend = !dyn && pend_reg && new_sf && pend_cnt_reg == 8'h00;   // RL15
  wire [31:0] cfg_sel = dyn ? bcfg_reg : (apply_pend ? cfg_pend_reg : cfg_act_reg); // RL16

  // Config fields: [7:0] preamble symbols, [15:8] unit count,
  // [19:16] cell prefix bytes, [22:20] access-control field bytes
  wire [7:0]  pre_len = cfg_use_reg[7:0];
  wire [2:0]  sac_len = cfg_use_reg[22:20];
  wire [15:0] units   = {8'h00, cfg_sel[15:8]};
  wire [15:0] mpeg_len = units * `RBF_TS_LEN;                               // RL22
  wire [15:0] cell_len = units * `RBF_CELL_LEN + {12'h000, cfg_sel[19:16]}; // RL23
  reg  [15:0] total_sel;
  always @*
  begin
    case (BURST_KIND)                                                       // RL21
      `RBF_KIND_TRF:   total_sel = ctrl_reg[`RBF_CTRL_CELL] ? cell_len : mpeg_len;
      `RBF_KIND_LOGON: total_sel = units;
      default:         total_sel = 16'h0000;
    endcase
  end

  // Access-control field bytes for sync bursts
  reg [7:0] sac_byte;
  always @*
  begin
    case (hdr_cnt_reg)
      3'h0:    sac_byte = sac_reg[7:0];                                     // RL9
      3'h1:    sac_byte = sac_reg[15:8];                                    // RL9
      3'h2:    sac_byte = sac_reg[23:16];                                   // RL18
      3'h3:    sac_byte = ctrl_reg[`RBF_CTRL_ACM] ? sac_reg[31:24] : 8'h00; // RL11
      default: sac_byte = 8'h00;
    endcase
  end
  wire hdr_left = kind_reg == `RBF_KIND_SYNC && hdr_cnt_reg < sac_len;      // RL7
  wire pay_left = byte_cnt_reg != total_reg;
  assign DIN_READY = state_reg == ST_BYTE && !hdr_left && pay_left;

  // Adaptation field control overwrite in each transport packet header
  wire afc_on = kind_reg == `RBF_KIND_TRF && !ctrl_reg[`RBF_CTRL_CELL]
             && ctrl_reg[`RBF_CTRL_AFC] && pkt_pos_reg == `RBF_TS_AFC_POS;
  wire [7:0] din_mod = afc_on ? {DIN[7:6], 1'b1, ctrl_reg[`RBF_CTRL_AFCPL], DIN[3:0]}
                              : DIN;                                        // RL8

  // Bit path: randomize, CRC, code
  wire prbs    = lfsr_reg[14] ^ lfsr_reg[13];
  wire rbit    = sh_reg[7] ^ prbs;                                          // RL1
  wire cbit    = state_reg == ST_CRC ? crc_reg[15] : rbit;
  wire fb      = cbit ^ enc_reg[1] ^ enc_reg[2] ^ (ctrl_reg[`RBF_CTRL_TAP] & enc_reg[0]); // RL4
  wire c1      = cbit;
  wire c2      = fb ^ enc_reg[0] ^ enc_reg[2];

  wire [PRE_AW-1:0] pre_rd = pre_cnt_reg[PRE_AW+3:4];
  wire [4:0] pre_bit = {pre_cnt_reg[3:0], 1'b0};
  rbf_pre_mem #(.DW(32), .AW(PRE_AW)) u_pre (
    .clk         (CLK),
    .wr_en       (wr_pre),
    .wr_addr     (aw_addr_reg[PRE_AW+1:2]),
    .wr_data     (wr_val),
    .rd_addr     (pre_rd),
    .rd_data_reg (pre_word)
  );

  // Register bus
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      aw_have_reg  <= 1'b0;
      w_have_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `RBF_RESP_OKAY;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RRESP  <= `RBF_RESP_OKAY;
      S_AXI_RDATA  <= 32'h0000_0000;
    end
    else
    begin
      if (S_AXI_AWVALID && !aw_have_reg)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= {S_AXI_AWADDR[7:2], 2'b00};
      end
      if (S_AXI_WVALID && !w_have_reg)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end
      if (wr_go)
      begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_map ? `RBF_RESP_OKAY : `RBF_RESP_SLVERR;
      end
      else if (S_AXI_BREADY)
      begin
        S_AXI_BVALID <= 1'b0;
      end
      if (S_AXI_ARVALID && !S_AXI_RVALID)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= `RBF_RESP_OKAY;
        case ({S_AXI_ARADDR[7:2], 2'b00})
          `RBF_OFS_CTRL:  S_AXI_RDATA <= ctrl_reg;
          `RBF_OFS_SLOT:  S_AXI_RDATA <= slot_reg;
          `RBF_OFS_BCFG:  S_AXI_RDATA <= bcfg_reg;
          `RBF_OFS_SAC:   S_AXI_RDATA <= sac_reg;
          `RBF_OFS_PID:   S_AXI_RDATA <= pid_reg;
          `RBF_OFS_DELAY: S_AXI_RDATA <= delay_reg;
          `RBF_OFS_STAT:  S_AXI_RDATA <= {crc_last_reg, burst_cnt_reg[11:0],
                                          pend_reg, pid_clash, miss_reg, slot_err_reg};
          default:
          begin
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= S_AXI_ARADDR[7:6] == `RBF_OFS_PRE >> 6
                           ? `RBF_RESP_OKAY : `RBF_RESP_SLVERR;
          end
        endcase
      end
      else if (S_AXI_RREADY)
      begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // Control registers, pending change and status flags
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ctrl_reg      <= `RBF_CTRL_RST;
      slot_reg      <= 32'h0000_0000;
      bcfg_reg      <= `RBF_BCFG_RST;
      sac_reg       <= 32'h0000_0000;
      pid_reg       <= 32'h0000_0000;
      delay_reg     <= 32'h0000_0000;
      cfg_act_reg   <= `RBF_BCFG_RST;
      cfg_pend_reg  <= `RBF_BCFG_RST;
      pend_reg      <= 1'b0;
      pend_cnt_reg  <= 8'h00;
      slot_err_reg  <= 1'b0;
      miss_reg      <= 1'b0;
      seen_reg      <= 1'b0;
      last_sfid_reg <= 8'h00;
      last_sfcnt_reg <= 8'h00;
      last_frame_reg <= 8'h00;
      last_slot_reg <= 8'h00;
    end
    else
    begin
      if (wr_ctrl) ctrl_reg <= wmerge(ctrl_reg, wr_val, w_strb_reg);
      if (wr_slot) slot_reg <= wmerge(slot_reg, wr_val, w_strb_reg);
      if (wr_sac)  sac_reg  <= wmerge(sac_reg, wr_val, w_strb_reg);
      if (wr_pid)  pid_reg  <= wmerge(pid_reg, wr_val, w_strb_reg);
      if (wr_dly)  delay_reg <= wmerge(delay_reg, wr_val, w_strb_reg);
      if (start_ok && new_sf && !dyn && pend_reg)
      begin
        if (pend_cnt_reg == 8'h00)
        begin
          cfg_act_reg <= cfg_pend_reg;                                      // RL15
          pend_reg    <= 1'b0;
        end
        else
        begin
          pend_cnt_reg <= pend_cnt_reg - 8'h01;
        end
      end
      if (wr_bcfg)
      begin
        bcfg_reg     <= wmerge(bcfg_reg, wr_val, w_strb_reg);
        cfg_pend_reg <= wmerge(bcfg_reg, wr_val, w_strb_reg);
        pend_reg     <= 1'b1;
        pend_cnt_reg <= delay_reg[7:0];                                     // RL15
      end
      if (start_ok)
      begin
        seen_reg       <= 1'b1;
        last_sfid_reg  <= SLOT_SFID;
        last_sfcnt_reg <= SLOT_SFCNT;
        last_frame_reg <= SLOT_FRAME;
        last_slot_reg  <= SLOT_NUM;
      end
      // Set wins over write-one-to-clear
      slot_err_reg <= order_bad | (slot_err_reg & ~(wr_stat & w_strb_reg[0] & wr_val[0]));
      miss_reg <= (start_try & ~key_ok) | (miss_reg & ~(wr_stat & w_strb_reg[0] & wr_val[1]));
    end
  end

  // Burst sequencer and symbol output
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_reg     <= ST_IDLE;
      kind_reg      <= `RBF_KIND_TRF;
      cfg_use_reg   <= `RBF_BCFG_RST;
      pre_cnt_reg   <= 8'h00;
      pre_ph_reg    <= 1'b0;
      byte_cnt_reg  <= 16'h0000;
      total_reg     <= 16'h0000;
      pkt_pos_reg   <= 8'h00;
      hdr_cnt_reg   <= 3'h0;
      sh_reg        <= 8'h00;
      bit_cnt_reg   <= 4'h0;
      lfsr_reg      <= `RBF_RAND_SEED;
      crc_reg       <= `RBF_CRC_INIT;
      enc_reg       <= 3'h0;
      crc_on_reg    <= 1'b0;
      crc_last_reg  <= 16'h0000;
      burst_cnt_reg <= 16'h0000;
      SYM_VALID     <= 1'b0;
      SYM_I         <= 1'b0;
      SYM_Q         <= 1'b0;
      BURST_DONE    <= 1'b0;
    end
    else
    begin
      SYM_VALID  <= 1'b0;
      BURST_DONE <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (start_ok)
          begin
            kind_reg     <= BURST_KIND;
            cfg_use_reg  <= cfg_sel;
            total_reg    <= total_sel;
            byte_cnt_reg <= 16'h0000;
            pkt_pos_reg  <= 8'h00;
            hdr_cnt_reg  <= 3'h0;
            pre_cnt_reg  <= 8'h00;
            pre_ph_reg   <= 1'b0;
            lfsr_reg     <= `RBF_RAND_SEED;                                 // RL24
            crc_reg      <= `RBF_CRC_INIT;
            enc_reg      <= 3'h0;
            crc_on_reg   <= ctrl_reg[`RBF_CTRL_CRC] && BURST_KIND[1];       // RL2
            state_reg    <= ST_PRE;
          end
        end
        ST_PRE:
        begin
          if (pre_cnt_reg == pre_len)
          begin
            state_reg <= kind_reg == `RBF_KIND_CAP ? ST_CRC : ST_BYTE;
            bit_cnt_reg <= 4'h0;
            crc_on_reg <= crc_on_reg & (kind_reg != `RBF_KIND_CAP);
          end
          else if (!pre_ph_reg)
          begin
            pre_ph_reg <= 1'b1;
          end
          else
          begin
            pre_ph_reg  <= 1'b0;
            SYM_VALID   <= 1'b1;
            SYM_I       <= pre_word[pre_bit + 5'd1];
            SYM_Q       <= pre_word[pre_bit];
            pre_cnt_reg <= pre_cnt_reg + 8'h01;
          end
        end
        ST_BYTE:
        begin
          bit_cnt_reg <= 4'h0;
          if (hdr_left)
          begin
            sh_reg      <= sac_byte;
            hdr_cnt_reg <= hdr_cnt_reg + 3'h1;
            state_reg   <= ST_BIT;
          end
          else if (!pay_left)
          begin
            state_reg <= ST_CRC;
          end
          else if (DIN_VALID)
          begin
            sh_reg       <= din_mod;
            byte_cnt_reg <= byte_cnt_reg + 16'h0001;
            pkt_pos_reg  <= pkt_pos_reg == `RBF_TS_LEN - 16'h0001 ? 8'h00
                                                                  : pkt_pos_reg + 8'h01;
            state_reg    <= ST_BIT;
          end
        end
        ST_BIT:
        begin
          lfsr_reg    <= {lfsr_reg[13:0], prbs};
          crc_reg     <= crc_step(crc_reg, rbit);                           // RL3
          enc_reg     <= {enc_reg[1:0], fb};
          SYM_VALID   <= 1'b1;
          SYM_I       <= c1;                                                // RL6
          SYM_Q       <= c2;                                                // RL5
          sh_reg      <= {sh_reg[6:0], 1'b0};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == 4'h7)
          begin
            state_reg <= ST_BYTE;
          end
        end
        ST_CRC:
        begin
          if (crc_on_reg)
          begin
            crc_reg     <= {crc_reg[14:0], 1'b0};                           // RL2
            enc_reg     <= {enc_reg[1:0], fb};
            SYM_VALID   <= 1'b1;
            SYM_I       <= c1;
            SYM_Q       <= c2;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'h0)
            begin
              crc_last_reg <= crc_reg;
            end
            if (bit_cnt_reg == 4'hF)
            begin
              crc_on_reg <= 1'b0;
            end
          end
          else
          begin
            BURST_DONE    <= 1'b1;
            burst_cnt_reg <= burst_cnt_reg + 16'h0001;
            state_reg     <= ST_IDLE;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // rbf_formatter
`default_nettype wire

// *** sim/rbf_formatter_chk.sv ***
// Port checker for the return burst formatter
`timescale 1ns/1ps
`default_nettype none
`include "rbf_defs.vh"
module rbf_chk (
  input wire logic        CLK,
  input wire logic        ARST_N,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        BURST_READY,
  input wire logic        DIN_VALID,
  input wire logic        DIN_READY,
  input wire logic        SYM_VALID,
  input wire logic        BURST_DONE
);
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
    && S_AXI_WREADY |=> !S_AXI_BVALID ##1 S_AXI_BVALID) else $error("write answer off");
  a_ready_free: assert property (S_AXI_BVALID |-> S_AXI_AWREADY && S_AXI_WREADY)
    else $error("write ready low");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  a_read_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("read overlap");
  a_unmapped_read: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 8'h20
    |=> S_AXI_RRESP == `RBF_RESP_SLVERR && S_AXI_RDATA == 32'h0) else $error("hole read");
  a_byte_symbols: assert property (DIN_VALID && DIN_READY |=> ##1 SYM_VALID [*8])
    else $error("byte symbols missing");
  a_done_busy: assert property (BURST_DONE |-> !SYM_VALID && !DIN_READY ##1 !BURST_DONE)
    else $error("done while active");
  a_idle_quiet: assert property (BURST_READY |-> !SYM_VALID && !DIN_READY)
    else $error("output while idle");
  c_done: cover property (BURST_DONE);
  c_byte: cover property (DIN_VALID && DIN_READY);
  c_slverr: cover property (S_AXI_BVALID && S_AXI_BRESP == `RBF_RESP_SLVERR);
endmodule // rbf_chk
bind rbf_formatter rbf_chk u_rbf_chk (.*);
`default_nettype wire

// *** sim/rbf_src.sv ***
// Payload source standing in for the terminal access layer
`timescale 1ns/1ps
`default_nettype none
module rbf_src (
  input  wire logic       CLK,
  input  wire logic       ARST_N,
  input  wire logic       DIN_READY,
  output var  logic [7:0] DIN,
  output var  logic       DIN_VALID
);
  logic [31:0] st;
  int          sent[$];
  // Random stalls; byte held until taken
  always @(posedge CLK or negedge ARST_N)
    if (!ARST_N)
    begin
      st <= 32'h0000_0035;
      DIN <= 8'h00;
      DIN_VALID <= 1'b0;
    end
    else if (DIN_VALID && DIN_READY)
    begin
      sent.push_back(DIN);
      DIN_VALID <= 1'b0;
      DIN <= ~DIN;
    end
    else if (!DIN_VALID)
    begin
      st <= {st[30:0], st[31] ^ st[21] ^ st[1] ^ st[0]};
      DIN_VALID <= st[3:2] != 2'h0;
      DIN <= (st[3:2] != 2'h0) ? st[15:8] : ~DIN;
    end
endmodule // rbf_src
`default_nettype wire

// *** sim/rbf_formatter_tb.sv ***
// Self-checking bench for the return burst formatter
`timescale 1ns/1ps
`default_nettype none
`include "rbf_defs.vh"
module rbf_formatter_tb;
  logic        clk = 1'b0, arst_n = 1'b0, start = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, sid = 8'h00, scnt = 8'h00, fno = 8'h00;
  logic [7:0]  sno = 8'h00;
  logic [1:0]  kind = 2'h0;
  logic [31:0] wdata = 32'h0, seed = 32'h4E, ctrl, bcfg, acc, pw[2];
  logic [15:0] last_crc;
  logic [1:0]  got[$];
  int          err_count = 0, samples_checked = 0, cyc = 0, bursts = 0;
  wire         aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, b_rdy, d_vld, d_rdy, s_vld, s_i, s_q, done;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [7:0]   din;
  rbf_formatter u_rbf_formatter (.CLK(clk), .ARST_N(arst_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(w_rdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(b_vld),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(r_vld),
    .S_AXI_RREADY(rready), .BURST_START(start), .BURST_KIND(kind), .SLOT_SFID(sid),
    .SLOT_SFCNT(scnt), .SLOT_FRAME(fno), .SLOT_NUM(sno), .BURST_READY(b_rdy), .DIN(din),
    .DIN_VALID(d_vld), .DIN_READY(d_rdy), .SYM_VALID(s_vld), .SYM_I(s_i), .SYM_Q(s_q),
    .BURST_DONE(done));
  rbf_src u_rbf_src (.CLK(clk), .ARST_N(arst_n), .DIN_READY(d_rdy), .DIN(din), .DIN_VALID(d_vld));
  always #2 clk = ~clk;
  always @(posedge clk)
    if (s_vld)
      got.push_back({s_i, s_q});
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_count++;
      results();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge clk);
      if (aw_rdy && !aw)
      begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (w_rdy && !w)
      begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!b_vld);
    bready <= 1'b0;
    chk(bresp, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, m, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!ar_rdy);
    arvalid <= 1'b0;
    do @(posedge clk); while (!r_vld);
    rready <= 1'b0;
    chk(rdata & m, d);
    chk(rresp, r);
  endtask
  // Runs one matched burst and compares each preamble symbol and the I bit of each coded symbol with the model
  task automatic burst(input logic [1:0] k, input logic [7:0] s);
    logic [14:0] pr;
    logic [15:0] crc;
    int q[$], dq[$], r;
    wr(`RBF_OFS_SLOT, {s, fno, scnt, sid}, `RBF_RESP_OKAY);
    got.delete();
    u_rbf_src.sent.delete();
    kind <= k;
    sno <= s;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    do @(posedge clk); while (!done);
    bursts++;
    for (int n = 0; n < bcfg[7:0]; n++)
      q.push_back({pw[n / 16][2 * (n % 16) + 1], pw[n / 16][2 * (n % 16)]});
    if (k == `RBF_KIND_SYNC)
      for (int n = 0; n < bcfg[22:20]; n++)
        dq.push_back((n == 3 && !ctrl[6]) ? 0 : acc[8 * n +: 8]);
    else if (k != `RBF_KIND_CAP)
      dq = u_rbf_src.sent;
    if (k == `RBF_KIND_TRF && ctrl[3])
      for (int n = 3; n < dq.size(); n += 188)
        dq[n] = {dq[n][7:6], 1'b1, ctrl[4], dq[n][3:0]};
    pr = `RBF_RAND_SEED;
    crc = `RBF_CRC_INIT;
    foreach (dq[i])
      for (int b = 7; b >= 0; b--)
      begin
        r = dq[i][b] ^ pr[14] ^ pr[13];
        pr = {pr[13:0], pr[14] ^ pr[13]};
        q.push_back(4 + r);
        crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ r[0]) ? `RBF_CRC_POLY : 16'h0000);
      end
    if (ctrl[2] && k[1])
      for (int b = 15; b >= 0; b--)
        q.push_back(4 + crc[b]);
    last_crc = crc;
    chk(got.size(), q.size());
    foreach (q[i])
      if (i < got.size())
        chk(q[i] > 3 ? got[i][1] : got[i], q[i] > 3 ? q[i] - 4 : q[i]);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(`RBF_OFS_CTRL, `RBF_CTRL_RST, 32'hFFFF_FFFF, `RBF_RESP_OKAY);
    rd(`RBF_OFS_BCFG, `RBF_BCFG_RST, 32'hFFFF_FFFF, `RBF_RESP_OKAY);
    rd(8'h20, 32'h0, 32'hFFFF_FFFF, `RBF_RESP_SLVERR);
    wr(8'h20, xs(), `RBF_RESP_SLVERR);
    pw[0] = xs();
    pw[1] = xs();
    acc = xs();
    {sid, scnt, fno} = xs();
    wr(`RBF_OFS_PRE, pw[0], `RBF_RESP_OKAY);
    wr(`RBF_OFS_PRE + 8'h04, pw[1], `RBF_RESP_OKAY);
    rd(`RBF_OFS_PRE, 32'h0, 32'hFFFF_FFFF, `RBF_RESP_OKAY);
    wr(`RBF_OFS_SAC, acc, `RBF_RESP_OKAY);
    wr(`RBF_OFS_PID, 32'h0022_0011, `RBF_RESP_OKAY);
    for (int m = 0; m < 2; m++)
    begin
      ctrl = 32'h07 | (m << 6);
      wr(`RBF_OFS_CTRL, ctrl, `RBF_RESP_OKAY);
      bcfg = 32'h0040_0214;
      wr(`RBF_OFS_BCFG, bcfg, `RBF_RESP_OKAY);
      burst(`RBF_KIND_SYNC, 8'h01 + 2 * m);
    end
    burst(`RBF_KIND_LOGON, 8'h05);
    rd(`RBF_OFS_STAT, {last_crc, 12'h003, 4'h8}, 32'hFFFF_FFFF, `RBF_RESP_OKAY);
    burst(`RBF_KIND_CAP, 8'h06);
    for (int m = 0; m < 2; m++)
    begin
      ctrl = 32'h0B | (m << 4);
      wr(`RBF_OFS_CTRL, ctrl, `RBF_RESP_OKAY);
      burst(`RBF_KIND_TRF, 8'h07 + m);
    end
    burst(`RBF_KIND_SYNC, 8'h03);
    rd(`RBF_OFS_STAT, 32'h1, 32'h1, `RBF_RESP_OKAY);
    wr(`RBF_OFS_SLOT, {8'h09, fno, scnt, ~sid}, `RBF_RESP_OKAY);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (4) @(posedge clk);
    rd(`RBF_OFS_STAT, {bursts[11:0], 4'hB}, 32'hFFFF, `RBF_RESP_OKAY);
    wr(`RBF_OFS_STAT, 32'h3, `RBF_RESP_OKAY);
    rd(`RBF_OFS_STAT, 32'h0, 32'h3, `RBF_RESP_OKAY);
    wr(`RBF_OFS_PID, 32'h0005_0005, `RBF_RESP_OKAY);
    rd(`RBF_OFS_STAT, 32'h4, 32'h4, `RBF_RESP_OKAY);
    results();
  end
endmodule // rbf_formatter_tb
`default_nettype wire
